// [include/radio_ctl_pkg.sv]
// Constants for the radio control-setting decode block
package radio_ctl_pkg;
   // ------------------------------------------------------------
   // Register addresses (4-bit address field)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_DIV_INT_FRAC_LO = 4'h3;
   localparam logic [3:0] ADDR_FRAC_HI = 4'h4;
   localparam logic [3:0] ADDR_SYNTH_CFG = 4'h5;
   localparam logic [3:0] ADDR_FILTER = 4'h7;
   localparam logic [3:0] ADDR_MODE = 4'h8;
   localparam logic [3:0] ADDR_TX_CFG = 4'h9;
   localparam logic [3:0] ADDR_PA_CFG = 4'hA;
   localparam logic [3:0] ADDR_TX_GAIN = 4'hC;
   localparam logic [3:0] ADDR_RX_CM = 4'hF;
   // ------------------------------------------------------------
   // Serial frame layout: 14 data bits then 4 address bits, MSB first
   // ------------------------------------------------------------
   localparam int DATA_BITS = 14;
   localparam int ADDR_BITS = 4;
   localparam int FRAME_BITS = 18;
   localparam logic [13:0] REG_RESET = 14'h0000;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int HP_SEL_LSB = 12;
   localparam int TX_FINE_LSB = 3;
   localparam int CM_TRIM_LSB = 10;
   localparam int MON_SRC_LSB = 8;
   localparam int MON_GATE_BIT = 10;
   localparam int GAIN_SRC_BIT = 10;
   localparam int PA_BIAS1_LSB = 0;
   localparam int PA_BIAS2_LSB = 3;
   localparam int PA_DLY_LSB = 10;
   localparam int REF_DIV_BIT = 2;
   localparam int FRAC_LO_LSB = 8;
   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] HP_100HZ = 2'h0;
   localparam logic [1:0] HP_4KHZ = 2'h1;
   localparam logic [1:0] HP_30KHZ = 2'h2;
   localparam logic [1:0] HP_600KHZ = 2'h3;
   localparam logic [1:0] MON_STRENGTH = 2'h0;
   localparam logic [1:0] MON_TEMP = 2'h1;
   localparam logic [1:0] MON_PDET = 2'h2;
   localparam logic [2:0] TX_FINE_MAX = 3'h5;
   // ------------------------------------------------------------
   // PA delay timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int PA_DLY_MIN_NS = 200;
   localparam int PA_DLY_MAX_NS = 7000;
   localparam int PA_DLY_MIN_CYC = (PA_DLY_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int PA_DLY_MAX_CYC = (PA_DLY_MAX_NS * CLK_MHZ) / 1000;
   localparam int PA_DLY_STEP_CYC = (PA_DLY_MAX_CYC - PA_DLY_MIN_CYC) / 15;
endpackage : radio_ctl_pkg

// [rtl/pa_delay_timer.sv]
// PA enable delay timer started on each transmit rising edge
`timescale 1ns/1ps
module pa_delay_timer #(
   parameter int CW = 9
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control
   input wire logic tx_on,
   input wire logic [3:0] delay_code,
   // Result
   output logic pa_enable
);
   logic [CW-1:0] cnt_q, cnt_d;
   logic tx_prev_q, tx_prev_d;
   logic pa_q, pa_d;
   logic [CW-1:0] target;

   assign target = CW'(radio_ctl_pkg::PA_DLY_MIN_CYC
      + int'(delay_code) * radio_ctl_pkg::PA_DLY_STEP_CYC);

   always_comb begin
      cnt_d = cnt_q;
      pa_d = pa_q;
      tx_prev_d = tx_on;
      if (!tx_on) begin
         cnt_d = '0;
         pa_d = 1'b0;
      end else if (!tx_prev_q) begin
         cnt_d = CW'(1);
         pa_d = 1'b0;
      end else if (!pa_q) begin
         if (cnt_q >= target) begin
            pa_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tx_prev_q <= 1'b0;
         pa_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tx_prev_q <= tx_prev_d;
         pa_q <= pa_d;
      end
   end

   assign pa_enable = pa_q;
endmodule : pa_delay_timer

// [rtl/radio_control_settings.sv]
// Serial configuration registers and analog control decode of the radio
`timescale 1ns/1ps
module radio_control_settings #(
   parameter int DELAY_CW = 9
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Serial port
   input wire logic ser_clk,
   input wire logic ser_cs_n,
   input wire logic ser_data,
   // Mode and gain pins
   input wire logic receive_transmit_select,
   input wire logic power_down_n,
   input wire logic highpass_corner_select,
   input wire logic [5:0] parallel_gain_pins,
   // Receive controls
   output logic rx_enable,
   output logic [1:0] rx_highpass_corner,
   output logic [1:0] rx_lowpass_coarse,
   output logic [1:0] rx_cm_trim,
   // Monitor output
   output logic monitor_enable,
   output logic [1:0] analog_monitor_out_sel,
   // Transmit controls
   output logic tx_enable,
   output logic [1:0] tx_lowpass_coarse,
   output logic [2:0] tx_lowpass_fine,
   output logic tx_fine_unused,
   output logic [5:0] tx_gain_code,
   output logic [5:0] tx_gain_atten_half_db,
   output logic [2:0] pa_bias_stage1,
   output logic [3:0] pa_bias_stage2,
   output logic pa_enable,
   // Synthesizer controls
   output logic ref_div_by_two,
   output logic [7:0] int_divider,
   output logic [19:0] frac_divider,
   output logic int_divider_out_of_range
);
   // ------------------------------------------------------------
   // Serial shift register
   // ------------------------------------------------------------
   localparam int FB = radio_ctl_pkg::FRAME_BITS;
   localparam int DB = radio_ctl_pkg::DATA_BITS;

   logic [FB-1:0] shift_q, shift_d;
   logic [4:0] bit_cnt_q, bit_cnt_d;
   logic sclk_prev_q, sclk_prev_d;
   logic cs_prev_q, cs_prev_d;
   logic wr_stb;
   logic [3:0] wr_addr;
   logic [DB-1:0] wr_data;

   always_comb begin
      shift_d = shift_q;
      bit_cnt_d = bit_cnt_q;
      sclk_prev_d = ser_clk;
      cs_prev_d = ser_cs_n;
      if (ser_cs_n) begin
         bit_cnt_d = '0;
      end else if (ser_clk && !sclk_prev_q) begin
         shift_d = {shift_q[FB-2:0], ser_data};
         if (bit_cnt_q != 5'h1F) begin
            bit_cnt_d = bit_cnt_q + 5'h01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         shift_q <= '0;
         bit_cnt_q <= '0;
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         shift_q <= shift_d;
         bit_cnt_q <= bit_cnt_d;
         sclk_prev_q <= sclk_prev_d;
         cs_prev_q <= cs_prev_d;
      end
   end

   // Frame completes on chip-select rise with exactly a full frame shifted
   assign wr_stb = ser_cs_n && !cs_prev_q && (bit_cnt_q == 5'(FB));
   assign wr_addr = shift_q[radio_ctl_pkg::ADDR_BITS-1:0];
   assign wr_data = shift_q[FB-1:radio_ctl_pkg::ADDR_BITS];

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [DB-1:0] reg3_q, reg3_d;
   logic [DB-1:0] reg4_q, reg4_d;
   logic [DB-1:0] reg5_q, reg5_d;
   logic [DB-1:0] reg7_q, reg7_d;
   logic [DB-1:0] reg8_q, reg8_d;
   logic [DB-1:0] reg9_q, reg9_d;
   logic [DB-1:0] reg10_q, reg10_d;
   logic [DB-1:0] reg12_q, reg12_d;
   logic [DB-1:0] reg15_q, reg15_d;

   always_comb begin
      reg3_d = reg3_q;
      reg4_d = reg4_q;
      reg5_d = reg5_q;
      reg7_d = reg7_q;
      reg8_d = reg8_q;
      reg9_d = reg9_q;
      reg10_d = reg10_q;
      reg12_d = reg12_q;
      reg15_d = reg15_q;
      if (wr_stb) begin
         unique case (wr_addr)
            radio_ctl_pkg::ADDR_DIV_INT_FRAC_LO: reg3_d = wr_data;
            radio_ctl_pkg::ADDR_FRAC_HI: reg4_d = wr_data;
            radio_ctl_pkg::ADDR_SYNTH_CFG: reg5_d = wr_data;
            radio_ctl_pkg::ADDR_FILTER: reg7_d = wr_data;
            radio_ctl_pkg::ADDR_MODE: reg8_d = wr_data;
            radio_ctl_pkg::ADDR_TX_CFG: reg9_d = wr_data;
            radio_ctl_pkg::ADDR_PA_CFG: reg10_d = wr_data;
            radio_ctl_pkg::ADDR_TX_GAIN: reg12_d = wr_data;
            radio_ctl_pkg::ADDR_RX_CM: reg15_d = wr_data;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg3_q <= radio_ctl_pkg::REG_RESET;
         reg4_q <= radio_ctl_pkg::REG_RESET;
         reg5_q <= radio_ctl_pkg::REG_RESET;
         reg7_q <= radio_ctl_pkg::REG_RESET;
         reg8_q <= radio_ctl_pkg::REG_RESET;
         reg9_q <= radio_ctl_pkg::REG_RESET;
         reg10_q <= radio_ctl_pkg::REG_RESET;
         reg12_q <= radio_ctl_pkg::REG_RESET;
         reg15_q <= radio_ctl_pkg::REG_RESET;
      end else begin
         reg3_q <= reg3_d;
         reg4_q <= reg4_d;
         reg5_q <= reg5_d;
         reg7_q <= reg7_d;
         reg8_q <= reg8_d;
         reg9_q <= reg9_d;
         reg10_q <= reg10_d;
         reg12_q <= reg12_d;
         reg15_q <= reg15_d;
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [1:0] hp_field, mon_src;
   logic [5:0] gain_sel;
   logic mon_on;
   logic tx_mode;

   assign tx_mode = receive_transmit_select && power_down_n;
   assign hp_field = reg7_q[radio_ctl_pkg::HP_SEL_LSB +: 2];
   assign mon_src = reg8_q[radio_ctl_pkg::MON_SRC_LSB +: 2];
   assign gain_sel = reg9_q[radio_ctl_pkg::GAIN_SRC_BIT]
      ? reg12_q[5:0] : parallel_gain_pins;

   always_comb begin
      mon_on = 1'b1;
      // Gate bit low: monitor dead while highpass pin low
      if (!reg8_q[radio_ctl_pkg::MON_GATE_BIT] && !highpass_corner_select) begin
         mon_on = 1'b0;
      end
      if (mon_src == radio_ctl_pkg::MON_STRENGTH && receive_transmit_select) begin
         mon_on = 1'b0;
      end
      if (mon_src == 2'h3) begin
         mon_on = 1'b0;
      end
   end

   // Registered outputs
   logic rx_en_q;
   logic [1:0] hp_q, rxlp_q, cm_q, mon_sel_q, txlp_q;
   logic mon_en_q, tx_en_q, fine_bad_q, ref_q, int_bad_q;
   logic [2:0] fine_q, b1_q;
   logic [3:0] b2_q;
   logic [5:0] gain_q, atten_q;
   logic [7:0] int_q;
   logic [19:0] frac_q;
   logic [1:0] hp_d;
   logic [5:0] atten_d;

   always_comb begin
      if (highpass_corner_select) begin
         hp_d = radio_ctl_pkg::HP_600KHZ;
      end else if (hp_field[0]) begin
         hp_d = radio_ctl_pkg::HP_4KHZ;
      end else if (hp_field[1]) begin
         hp_d = radio_ctl_pkg::HP_30KHZ;
      end else begin
         hp_d = radio_ctl_pkg::HP_100HZ;
      end
      // Attenuation in half-dB units below maximum
      if (gain_sel >= 6'h30) begin
         atten_d = 6'h3F - gain_sel;
      end else begin
         atten_d = {(5'h17 - gain_sel[5:1]), 1'b0} + 6'h10;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_en_q <= 1'b0;
         hp_q <= radio_ctl_pkg::HP_100HZ;
         rxlp_q <= 2'h0;
         cm_q <= 2'h0;
         mon_en_q <= 1'b0;
         mon_sel_q <= radio_ctl_pkg::MON_STRENGTH;
         tx_en_q <= 1'b0;
         txlp_q <= 2'h0;
         fine_q <= 3'h0;
         fine_bad_q <= 1'b0;
         gain_q <= 6'h00;
         atten_q <= 6'h00;
         b1_q <= 3'h0;
         b2_q <= 4'h0;
         ref_q <= 1'b0;
         int_q <= 8'h00;
         frac_q <= 20'h00000;
         int_bad_q <= 1'b0;
      end else begin
         rx_en_q <= !receive_transmit_select && power_down_n;
         hp_q <= hp_d;
         rxlp_q <= reg8_q[1:0];
         cm_q <= reg15_q[radio_ctl_pkg::CM_TRIM_LSB +: 2];
         mon_en_q <= mon_on;
         mon_sel_q <= mon_src;
         tx_en_q <= tx_mode;
         txlp_q <= reg8_q[1:0];
         fine_q <= reg7_q[radio_ctl_pkg::TX_FINE_LSB +: 3];
         fine_bad_q <= reg7_q[radio_ctl_pkg::TX_FINE_LSB +: 3]
            > radio_ctl_pkg::TX_FINE_MAX;
         gain_q <= gain_sel;
         atten_q <= atten_d;
         b1_q <= reg10_q[radio_ctl_pkg::PA_BIAS1_LSB +: 3];
         b2_q <= reg10_q[radio_ctl_pkg::PA_BIAS2_LSB +: 4];
         ref_q <= reg5_q[radio_ctl_pkg::REF_DIV_BIT];
         int_q <= reg3_q[7:0];
         int_bad_q <= reg3_q[7:6] == 2'h0;
         frac_q <= {reg4_q, reg3_q[radio_ctl_pkg::FRAC_LO_LSB +: 6]};
      end
   end

   // ------------------------------------------------------------
   // PA enable delay
   // ------------------------------------------------------------
   pa_delay_timer #(
      .CW(DELAY_CW)
   ) u_pa_delay (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tx_on(tx_mode),
      .delay_code(reg10_q[radio_ctl_pkg::PA_DLY_LSB +: 4]),
      .pa_enable(pa_enable)
   );

   assign rx_enable = rx_en_q;
   assign rx_highpass_corner = hp_q;
   assign rx_lowpass_coarse = rxlp_q;
   assign rx_cm_trim = cm_q;
   assign monitor_enable = mon_en_q;
   assign analog_monitor_out_sel = mon_sel_q;
   assign tx_enable = tx_en_q;
   assign tx_lowpass_coarse = txlp_q;
   assign tx_lowpass_fine = fine_q;
   assign tx_fine_unused = fine_bad_q;
   assign tx_gain_code = gain_q;
   assign tx_gain_atten_half_db = atten_q;
   assign pa_bias_stage1 = b1_q;
   assign pa_bias_stage2 = b2_q;
   assign ref_div_by_two = ref_q;
   assign int_divider = int_q;
   assign frac_divider = frac_q;
   assign int_divider_out_of_range = int_bad_q;
endmodule : radio_control_settings

// [verif/baseband_serial_model.sv]
// Controller model that sends serial register frames
`timescale 1ns/1ps
module baseband_serial_model (
   // Clock
   input wire logic sys_clk,
   // Request
   input wire logic go,
   input wire logic [17:0] frame,
   input wire logic [4:0] nbits,
   output logic busy,
   // Serial port
   output logic ser_clk,
   output logic ser_cs_n,
   output logic ser_data
);
   initial begin
      busy = 1'b0;
      ser_clk = 1'b0;
      ser_cs_n = 1'b1;
      ser_data = 1'b0;
   end
   // Two cycles low, two high per bit; data steady over each bit
   always begin
      @(posedge sys_clk);
      if (go) begin
         busy <= 1'b1;
         ser_cs_n <= 1'b0;
         for (int i = 0; i < nbits; i++) begin
            ser_data <= frame[17 - i];
            ser_clk <= 1'b0;
            repeat (2) @(posedge sys_clk);
            ser_clk <= 1'b1;
            repeat (2) @(posedge sys_clk);
         end
         ser_clk <= 1'b0;
         ser_cs_n <= 1'b1;
         // Released line shows no stale bit
         ser_data <= ~ser_data;
         repeat (2) @(posedge sys_clk);
         busy <= 1'b0;
      end
   end
endmodule : baseband_serial_model

// [verif/radio_control_settings_monitor.sv]
// Port checker for the radio control decode block
`timescale 1ns/1ps
module radio_control_settings_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Mode pins
   input wire logic receive_transmit_select,
   input wire logic power_down_n,
   input wire logic highpass_corner_select,
   // Decoded outputs
   input wire logic rx_enable,
   input wire logic tx_enable,
   input wire logic [1:0] rx_highpass_corner,
   input wire logic [1:0] rx_lowpass_coarse,
   input wire logic [1:0] tx_lowpass_coarse,
   input wire logic monitor_enable,
   input wire logic [1:0] analog_monitor_out_sel,
   input wire logic [5:0] tx_gain_code,
   input wire logic [5:0] tx_gain_atten_half_db,
   input wire logic pa_enable,
   input wire logic [7:0] int_divider,
   input wire logic int_divider_out_of_range
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [5:0] att_exp;
   // Half dB steps on top codes, then pairs of codes share 1 dB
   always_comb begin
      if (tx_gain_code >= 6'h30) att_exp = 6'h3F - tx_gain_code;
      else att_exp = ((6'h2F - tx_gain_code) & 6'h3E) + 6'h10;
   end
   chk_tx_on_pins: assert property ($past(rst_n) && receive_transmit_select && power_down_n
      |=> tx_enable && !rx_enable) else $error("transmit enable wrong");
   chk_rx_on_pins: assert property ($past(rst_n) && !receive_transmit_select && power_down_n
      |=> rx_enable && !tx_enable) else $error("receive enable wrong");
   chk_off_shutdown: assert property (!power_down_n |=> !rx_enable && !tx_enable)
      else $error("enable during shutdown");
   chk_hp_forced: assert property ($past(rst_n) && highpass_corner_select
      |=> rx_highpass_corner == radio_ctl_pkg::HP_600KHZ) else $error("highpass not forced");
   chk_mon_strength_tx: assert property (receive_transmit_select
      |=> analog_monitor_out_sel != radio_ctl_pkg::MON_STRENGTH || !monitor_enable)
      else $error("strength monitor on in transmit");
   chk_coarse_shared: assert property (rx_lowpass_coarse == tx_lowpass_coarse)
      else $error("coarse corners differ");
   chk_atten_map: assert property ($past(rst_n) |-> tx_gain_atten_half_db == att_exp)
      else $error("gain attenuation wrong");
   chk_int_range: assert property ($past(rst_n) |-> int_divider_out_of_range == (int_divider < 8'h40))
      else $error("range flag wrong");
   chk_pa_min_wait: assert property ($rose(tx_enable) |-> !pa_enable [*6])
      else $error("PA enabled too early");
   cover property ($rose(pa_enable));
   cover property (monitor_enable && analog_monitor_out_sel == 2'h2);
   cover property (int_divider_out_of_range);
endmodule : radio_control_settings_monitor

bind radio_control_settings radio_control_settings_monitor radio_control_settings_monitor_inst (
   .sys_clk, .rst_n, .receive_transmit_select, .power_down_n, .highpass_corner_select,
   .rx_enable, .tx_enable, .rx_highpass_corner, .rx_lowpass_coarse, .tx_lowpass_coarse,
   .monitor_enable, .analog_monitor_out_sel, .tx_gain_code, .tx_gain_atten_half_db,
   .pa_enable, .int_divider, .int_divider_out_of_range
);

// [verif/radio_control_settings_test.sv]
// Self-checking bench for the radio control decode block
`timescale 1ns/1ps
module radio_control_settings_test;
   logic sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0, busy, ser_clk, ser_cs_n, ser_data;
   logic receive_transmit_select = 1'b0, power_down_n = 1'b0, highpass_corner_select = 1'b0;
   logic [5:0] parallel_gain_pins = 6'h00;
   logic [17:0] frame = 18'h00000;
   logic [4:0] nbits = 5'h12;
   logic rx_enable, monitor_enable, tx_enable, tx_fine_unused, pa_enable, ref_div_by_two;
   logic int_divider_out_of_range;
   logic [1:0] rx_highpass_corner, rx_lowpass_coarse, rx_cm_trim, analog_monitor_out_sel;
   logic [1:0] tx_lowpass_coarse;
   logic [2:0] tx_lowpass_fine, pa_bias_stage1;
   logic [3:0] pa_bias_stage2;
   logic [5:0] tx_gain_code, tx_gain_atten_half_db;
   logic [7:0] int_divider;
   logic [19:0] frac_divider;
   logic [3:0] pa_codes [3] = '{4'h0, 4'h1, 4'hF};
   int n_errors = 0, checked = 0;
   always #12.5 sys_clk = ~sys_clk;
   radio_control_settings radio_control_settings_inst (
      .sys_clk, .rst_n, .ser_clk, .ser_cs_n, .ser_data, .receive_transmit_select,
      .power_down_n, .highpass_corner_select, .parallel_gain_pins, .rx_enable,
      .rx_highpass_corner, .rx_lowpass_coarse, .rx_cm_trim, .monitor_enable,
      .analog_monitor_out_sel, .tx_enable, .tx_lowpass_coarse, .tx_lowpass_fine,
      .tx_fine_unused, .tx_gain_code, .tx_gain_atten_half_db, .pa_bias_stage1,
      .pa_bias_stage2, .pa_enable, .ref_div_by_two, .int_divider, .frac_divider,
      .int_divider_out_of_range
   );
   baseband_serial_model baseband_serial_model_inst (
      .sys_clk, .go, .frame, .nbits, .busy, .ser_clk, .ser_cs_n, .ser_data
   );
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic await(input logic lvl);
      int k;
      for (k = 0; k < 300 && busy !== lvl; k++) @(posedge sys_clk);
      if (k == 300) begin
         n_errors++;
         tally_and_finish();
      end
   endtask : await
   // Frame is 14 data bits then 4 address bits
   task automatic wr(input logic [3:0] a, input logic [13:0] d, input logic [4:0] nb = 5'h12);
      @(posedge sys_clk);
      frame <= {d, a};
      nbits <= nb;
      go <= 1'b1;
      await(1'b1);
      go <= 1'b0;
      await(1'b0);
      repeat (2) @(posedge sys_clk);
   endtask : wr
   initial begin
      int n, e;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      power_down_n <= 1'b1;
      chk("int", int_divider, 8'h00);
      wr(4'h3, 14'h1A79);
      wr(4'h4, 14'h3666);
      chk("int", int_divider, 8'h79);
      chk("frac", frac_divider, 20'hD999A);
      chk("range", int_divider_out_of_range, 1'b0);
      chk("rx", rx_enable, 1'b1);
      wr(4'h2, 14'h3FFF);
      wr(4'h3, 14'h0040, 5'h11);
      chk("int", int_divider, 8'h79);
      chk("frac", frac_divider, 20'hD999A);
      wr(4'h3, 14'h003F);
      chk("range", int_divider_out_of_range, 1'b1);
      chk("frac", frac_divider, 20'hD9980);
      for (int i = 0; i < 8; i++) begin
         wr(4'h7, {i[1:0], 6'h00, i[2:0], 3'h0});
         chk("hp", rx_highpass_corner, i[0] ? 2'h1 : i[1:0]);
         chk("fine", tx_lowpass_fine, i[2:0]);
         chk("unused", tx_fine_unused, i > 5);
      end
      highpass_corner_select <= 1'b1;
      wr(4'hF, 14'h0800);
      chk("hp", rx_highpass_corner, 2'h3);
      chk("trim", rx_cm_trim, 2'h2);
      for (int j = 0; j < 8; j++) begin
         wr(4'h8, {3'h0, j[2:0], 6'h00, j[1:0]});
         chk("sel", analog_monitor_out_sel, j[1:0]);
         chk("txc", tx_lowpass_coarse, j[1:0]);
         chk("rxc", rx_lowpass_coarse, j[1:0]);
         chk("mon", monitor_enable, j[1:0] != 2'h3);
         highpass_corner_select <= 1'b0;
         repeat (2) @(posedge sys_clk);
         chk("mon", monitor_enable, j[2] && j[1:0] != 2'h3);
         receive_transmit_select <= 1'b1;
         repeat (2) @(posedge sys_clk);
         chk("mon", monitor_enable, j[2] && j[1:0] != 2'h3 && j[1:0] != 2'h0);
         receive_transmit_select <= 1'b0;
         highpass_corner_select <= 1'b1;
         repeat (2) @(posedge sys_clk);
      end
      parallel_gain_pins <= 6'h2D;
      wr(4'h9, 14'h0000);
      wr(4'hC, 14'h0031);
      chk("gain", tx_gain_code, 6'h2D);
      chk("att", tx_gain_atten_half_db, 6'h12);
      wr(4'h9, 14'h0400);
      chk("gain", tx_gain_code, 6'h31);
      chk("att", tx_gain_atten_half_db, 6'h0E);
      wr(4'h5, 14'h0004);
      chk("ref", ref_div_by_two, 1'b1);
      for (int c = 0; c < 3; c++) begin
         wr(4'hA, {pa_codes[c], 3'h0, 4'h9, 3'h5});
         chk("bias1", pa_bias_stage1, 3'h5);
         chk("bias2", pa_bias_stage2, 4'h9);
         receive_transmit_select <= 1'b1;
         n = 0;
         while (pa_enable !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            n++;
         end
         e = radio_ctl_pkg::PA_DLY_MIN_CYC + pa_codes[c] * radio_ctl_pkg::PA_DLY_STEP_CYC + 1;
         chk("pa_wait", (n + 1 >= e) && (n <= e + 2), 1'b1);
         chk("tx", tx_enable, 1'b1);
         receive_transmit_select <= 1'b0;
         repeat (3) @(posedge sys_clk);
         chk("pa", pa_enable, 1'b0);
      end
      receive_transmit_select <= 1'b1;
      power_down_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("tx", tx_enable, 1'b0);
      chk("rx", rx_enable, 1'b0);
      tally_and_finish();
   end
endmodule : radio_control_settings_test
